// file: rph_consts.svh
`ifndef RPH_CONSTS_SVH
`define RPH_CONSTS_SVH

`define RPH_ADDR_W        4
`define RPH_A_AUTOCTL     4'h0
`define RPH_A_FILTCTL     4'h1
`define RPH_A_LENLIM      4'h2
`define RPH_A_SYNCHI      4'h3
`define RPH_A_SYNCLO      4'h4
`define RPH_A_MDMB        4'h5
`define RPH_A_MDMC        4'h6
`define RPH_A_ADDR        4'h7
`define RPH_A_STATUS      4'h8
`define RPH_A_CMD         4'h9
`define RPH_A_PQT         4'hA
`define RPH_AUTO_RST      8'h05
`define RPH_FILT_RST      8'h04
`define RPH_LEN_RST       8'hFF
`define RPH_SYNCHI_RST    8'hD3
`define RPH_SYNCLO_RST    8'h91
`define RPH_MDMB_RST      8'h22
`define RPH_MDMC_RST      8'h02
`define RPH_PQT_RST       8'h00
`define RPH_PREAMBLE      8'hAA
`define RPH_PN9_SEED      9'h1FF
`define RPH_CRC_SEED      16'hFFFF
`define RPH_CRC_POLY      16'h8005
`define RPH_LEN_FIXED     2'h0
`define RPH_LEN_VAR       2'h1
`define RPH_LEN_INF       2'h2
`define RPH_SYNC_A        3'h3
`define RPH_SYNC_B        3'h7
`define RPH_BCAST0        8'h00
`define RPH_BCASTF        8'hFF
`define RPH_ADR_B0        2'h2
`define RPH_ADR_BF        2'h3
`define RPH_ST_DONE       2'h0
`define RPH_CMD_TX        0
`define RPH_CMD_RX        1
`define RPH_CMD_IDLE      2
`define RPH_CMD_TX_FIFO_FLUSH_STROBE      3
`define RPH_CMD_SFRX      4
`define RPH_BIT_WHITE     6
`define RPH_BIT_CRC       2
`define RPH_BIT_APPEND    2
`define RPH_BIT_FLUSH     3
`define RPH_BIT_FEC       7
`define RPH_THR_15        5'h0F
`define RPH_THR_16        5'h10
`define RPH_THR_30        6'h1E
`define RPH_ONE8          8'h01
`define RPH_ONE3          3'h1

`endif

// file: rph_pkg.sv
package rph_pkg;
  typedef enum logic [3:0] {
    RPH_IDLE     = 4'b0000,
    RPH_TX_PRE   = 4'b0001,
    RPH_TX_SYNC  = 4'b0010,
    RPH_TX_DATA  = 4'b0011,
    RPH_TX_CRC   = 4'b0100,
    RPH_TX_UFLOW = 4'b0101,
    RPH_RX_HUNT  = 4'b0110,
    RPH_RX_DATA  = 4'b0111,
    RPH_RX_CRC   = 4'b1000,
    RPH_RX_ST1   = 4'b1001,
    RPH_RX_ST2   = 4'b1010
  } rph_state_type;
endpackage

// file: rph_packet_handler.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "rph_consts.svh"
// Behaviour
// - transmit always sends preamble and sync
// - preamble is 10101010 repeated count plus one times
// - preamble repeats until transmit data exists
// - sync is high,low; doubled in modes 3,7
// - sync match thresholds 15/16, 16/16, 30/32
// - preamble quality must exceed threshold
// - whitening XORs data with nine bit sequence
// - whitening generator reseeds to ones per packet
// - whitening and coding cover data and CRC
// - CRC appended on transmit, checked on receive
// - length mode 0 uses length register
// - mode 1 first byte gives payload length
// - receive length above limit discards packet
// - mode 2 runs until host stops
// - lengths one to 255 bytes supported
// - length and control writable mid packet
// - packet end enters configured next state; transmit decodes only 2 and 3, receive only 3, all other values give idle
// - first status byte holds signal strength
// - second status byte CRC flag, link quality
// - address filter with broadcast options
// - underflow holds until transmit flush strobe
// - failed CRC may flush whole receive FIFO
module rph_packet_handler (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic [`RPH_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  input  wire logic                    tx_fifo_valid_i,
  input  wire logic [7:0]              tx_fifo_data_i,
  output logic                         tx_fifo_pop_o,
  output logic                         tx_byte_valid_o,
  output logic      [7:0]              tx_byte_o,
  input  wire logic                    tx_byte_ready_i,
  input  wire logic                    rx_bit_valid_i,
  input  wire logic                    rx_bit_i,
  input  wire logic [7:0]              signal_strength_value_i,
  input  wire logic [6:0]              link_quality_value_i,
  input  wire logic [7:0]              preamble_quality_indicator_i,
  output logic                         rx_fifo_push_o,
  output logic      [7:0]              rx_fifo_data_o,
  output logic                         rx_fifo_flush_o,
  output logic                         rx_packet_drop_o,
  output logic                         fec_enable_o,
  output logic                         tx_active_o,
  output logic                         rx_active_o
);
  // Registers.
  logic [7:0] packet_automation_control_reg;
  logic [7:0] packet_filter_control_reg;
  logic [7:0] packet_length_limit_reg;
  logic [7:0] sync_high_byte_reg;
  logic [7:0] sync_low_byte_reg;
  logic [7:0] modem_config_b_reg;
  logic [7:0] modem_config_c_reg;
  logic [7:0] node_address_reg;
  logic [7:0] pq_threshold_reg;
  logic [7:0] rdata_next;
  logic [7:0] cmd_pulse;

  rph_pkg::rph_state_type state_reg;
  rph_pkg::rph_state_type state_next;

  logic [7:0]  byte_cnt_reg;
  logic [7:0]  byte_cnt_next;
  logic [7:0]  pre_cnt_reg;
  logic [2:0]  sync_idx_reg;
  logic [8:0]  pn9_reg;
  logic [15:0] crc_reg;
  logic [15:0] rx_crc_reg;
  logic        crc_bad_reg;
  logic [31:0] rx_shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  rx_byte_reg;
  logic        rx_byte_stb_reg;
  logic [7:0]  cur_len_reg;
  logic        hdr_len_reg;
  logic        hdr_adr_reg;
  logic [7:0]  tx_byte_reg;
  logic        tx_valid_reg;
  logic [7:0]  rx_push_data_reg;
  logic        rx_push_reg;
  logic        flush_reg;
  logic        drop_reg;
  logic        rx_bit_s1_reg;
  logic        rx_bit_s2_reg;
  logic        rx_vld_s1_reg;
  logic        rx_vld_s2_reg;

  wire [1:0] len_mode    = packet_automation_control_reg[1:0];
  wire       white_en    = packet_automation_control_reg[`RPH_BIT_WHITE];
  wire       crc_en      = packet_automation_control_reg[`RPH_BIT_CRC];
  wire [1:0] adr_mode    = packet_filter_control_reg[1:0];
  wire       append_en   = packet_filter_control_reg[`RPH_BIT_APPEND];
  wire       flush_en    = packet_filter_control_reg[`RPH_BIT_FLUSH];
  wire [2:0] num_pre     = modem_config_b_reg[6:4];
  wire [1:0] tx_end_next_state = modem_config_b_reg[1:0];
  wire [1:0] rx_end_next_state = modem_config_c_reg[7:6];
  wire [2:0] sync_mode   = modem_config_c_reg[2:0];
  wire       pq_en       = modem_config_c_reg[3];
  wire       sync32      = (sync_mode == `RPH_SYNC_A) || (sync_mode == `RPH_SYNC_B);
  wire [15:0] sync16     = {sync_high_byte_reg, sync_low_byte_reg};
  wire [31:0] sync_full  = {sync16, sync16};

  // One-cycle command strobes decoded from the command register write.
  wire cmd_wr = reg_wr_i && (reg_addr_i == `RPH_A_CMD);
  assign cmd_pulse = cmd_wr ? reg_wdata_i : 8'h00;

  // Pin-domain receive bits are synchronised before use.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_bit_s1_reg <= 1'b0;
      rx_bit_s2_reg <= 1'b0;
      rx_vld_s1_reg <= 1'b0;
      rx_vld_s2_reg <= 1'b0;
    end else begin
      rx_bit_s1_reg <= rx_bit_i;
      rx_bit_s2_reg <= rx_bit_s1_reg;
      rx_vld_s1_reg <= rx_bit_valid_i;
      rx_vld_s2_reg <= rx_vld_s1_reg;
    end
  end

  // Edge of the synchronised valid marks one new bit.
  logic rx_vld_d_reg;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) rx_vld_d_reg <= 1'b0;
    else rx_vld_d_reg <= rx_vld_s2_reg;
  end
  wire rx_bit_stb = rx_vld_s2_reg && !rx_vld_d_reg;

  // Sync correlator: count matching bits.
  logic [5:0] match32;
  logic [4:0] match16;
  always_comb begin
    match32 = 6'h00;
    match16 = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (rx_shift_reg[i] == sync_full[i]) begin
        match32 = match32 + 6'h01;
        if (i < 16) match16 = match16 + 5'h01;
      end
    end
  end
  wire thr_hit = sync32 ? (match32 >= `RPH_THR_30) :
                 (sync_mode[1:0] == 2'h2) ? (match16 >= `RPH_THR_16) :
                 (match16 >= `RPH_THR_15);
  wire pq_ok   = !pq_en || (preamble_quality_indicator_i > pq_threshold_reg);
  wire sync_found = (sync_mode != 3'h0) && thr_hit && pq_ok;

  // PN9 advanced eight steps, producing one whitening byte.
  function automatic logic [16:0] pn9_step8(input logic [8:0] s);
    logic [8:0] t;
    logic [7:0] w;
    t = s;
    w = 8'h00;
    for (int k = 0; k < 8; k++) begin
      w[k] = t[0];
      t = {t[5] ^ t[0], t[8:1]};
    end
    return {t, w};
  endfunction
  wire [16:0] pn_out  = pn9_step8(pn9_reg);
  wire [7:0]  pn_byte = white_en ? pn_out[7:0] : 8'h00;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = (r[15] ^ d[k]) ? ((r << 1) ^ `RPH_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Length end test against the live limit register in mode 0, the received length byte in mode 1.
  wire [7:0] len_target = (len_mode == `RPH_LEN_VAR) ? cur_len_reg : packet_length_limit_reg;
  wire       at_end     = (len_mode != `RPH_LEN_INF) && (byte_cnt_next == len_target);
  assign byte_cnt_next = byte_cnt_reg + `RPH_ONE8;

  wire tx_go   = tx_byte_ready_i || !tx_valid_reg;
  wire adr_ok  = (rx_byte_reg == node_address_reg) ||
                 ((adr_mode == `RPH_ADR_B0 || adr_mode == `RPH_ADR_BF) && rx_byte_reg == `RPH_BCAST0) ||
                 ((adr_mode == `RPH_ADR_BF) && rx_byte_reg == `RPH_BCASTF);
  wire [7:0] rx_plain = rx_byte_reg ^ pn_byte;
  wire rx_stop = cmd_pulse[`RPH_CMD_IDLE];
  wire rx_next_is_rx = (rx_end_next_state == 2'h3);
  wire tx_next_is_rx = (tx_end_next_state == 2'h3);
  wire tx_next_is_tx = (tx_end_next_state == 2'h2);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= rph_pkg::RPH_IDLE;
      byte_cnt_reg <= 8'h00;
      pre_cnt_reg <= 8'h00;
      sync_idx_reg <= 3'h0;
      pn9_reg <= `RPH_PN9_SEED;
      crc_reg <= `RPH_CRC_SEED;
      rx_crc_reg <= 16'h0000;
      crc_bad_reg <= 1'b0;
      rx_shift_reg <= 32'h0000_0000;
      bit_cnt_reg <= 3'h0;
      rx_byte_reg <= 8'h00;
      rx_byte_stb_reg <= 1'b0;
      cur_len_reg <= 8'h00;
      hdr_len_reg <= 1'b0;
      hdr_adr_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      rx_push_data_reg <= 8'h00;
      rx_push_reg <= 1'b0;
      flush_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      flush_reg <= cmd_pulse[`RPH_CMD_SFRX];
      drop_reg <= 1'b0;
      rx_byte_stb_reg <= 1'b0;
      if (tx_byte_ready_i) tx_valid_reg <= 1'b0;
      if (rx_bit_stb) begin
        rx_shift_reg <= {rx_shift_reg[30:0], rx_bit_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + `RPH_ONE3;
        if (bit_cnt_reg == 3'h7) begin
          rx_byte_reg <= {rx_shift_reg[6:0], rx_bit_s2_reg};
          rx_byte_stb_reg <= 1'b1;
        end
      end
      case (state_reg)
        rph_pkg::RPH_IDLE: begin
          pre_cnt_reg <= 8'h00;
          if (cmd_pulse[`RPH_CMD_TX]) state_reg <= rph_pkg::RPH_TX_PRE;
          else if (cmd_pulse[`RPH_CMD_RX]) state_reg <= rph_pkg::RPH_RX_HUNT;
        end
        rph_pkg::RPH_TX_PRE: if (tx_go) begin
          tx_byte_reg <= `RPH_PREAMBLE;
          tx_valid_reg <= 1'b1;
          pre_cnt_reg <= pre_cnt_reg + {7'h00, ~&pre_cnt_reg};
          // Preamble continues while the FIFO is empty; the count saturates.
          if (pre_cnt_reg >= {5'h00, num_pre} && tx_fifo_valid_i) begin
            state_reg <= rph_pkg::RPH_TX_SYNC;
            sync_idx_reg <= 3'h0;
          end
        end
        rph_pkg::RPH_TX_SYNC: if (tx_go) begin
          tx_byte_reg <= sync_idx_reg[0] ? sync_low_byte_reg : sync_high_byte_reg;
          tx_valid_reg <= 1'b1;
          sync_idx_reg <= sync_idx_reg + `RPH_ONE3;
          if (sync_idx_reg == (sync32 ? 3'h3 : 3'h1)) begin
            state_reg <= rph_pkg::RPH_TX_DATA;
            pn9_reg <= `RPH_PN9_SEED;
            crc_reg <= `RPH_CRC_SEED;
            byte_cnt_reg <= 8'h00;
            hdr_len_reg <= (len_mode == `RPH_LEN_VAR);
          end
        end
        rph_pkg::RPH_TX_DATA: if (tx_go) begin
          if (!tx_fifo_valid_i) state_reg <= rph_pkg::RPH_TX_UFLOW;
          else begin
            tx_byte_reg <= tx_fifo_data_i ^ pn_byte;
            tx_valid_reg <= 1'b1;
            pn9_reg <= pn_out[16:8];
            crc_reg <= crc_byte(crc_reg, tx_fifo_data_i);
            if (hdr_len_reg) begin
              cur_len_reg <= tx_fifo_data_i;
              hdr_len_reg <= 1'b0;
            end else begin
              byte_cnt_reg <= byte_cnt_next;
              if (at_end) begin
                sync_idx_reg <= 3'h0;
                state_reg <= crc_en ? rph_pkg::RPH_TX_CRC :
                             tx_next_is_tx ? rph_pkg::RPH_TX_PRE :
                             tx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
                pre_cnt_reg <= 8'h00;
              end
            end
          end
          if (rx_stop) state_reg <= rph_pkg::RPH_IDLE;
        end
        rph_pkg::RPH_TX_CRC: if (tx_go) begin
          tx_byte_reg <= (sync_idx_reg[0] ? crc_reg[7:0] : crc_reg[15:8]) ^ pn_byte;
          tx_valid_reg <= 1'b1;
          pn9_reg <= pn_out[16:8];
          sync_idx_reg <= sync_idx_reg + `RPH_ONE3;
          if (sync_idx_reg[0]) begin
            pre_cnt_reg <= 8'h00;
            state_reg <= tx_next_is_tx ? rph_pkg::RPH_TX_PRE :
                         tx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
          end
        end
        rph_pkg::RPH_TX_UFLOW: begin
          if (cmd_pulse[`RPH_CMD_TX_FIFO_FLUSH_STROBE]) state_reg <= rph_pkg::RPH_IDLE;
        end
        rph_pkg::RPH_RX_HUNT: begin
          // A match is taken only in a cycle with no new bit, on the settled shift.
          if (sync_found && !rx_bit_stb) begin
            state_reg <= rph_pkg::RPH_RX_DATA;
            rx_shift_reg <= 32'h0000_0000;
            bit_cnt_reg <= 3'h0;
            pn9_reg <= `RPH_PN9_SEED;
            crc_reg <= `RPH_CRC_SEED;
            byte_cnt_reg <= 8'h00;
            hdr_len_reg <= (len_mode == `RPH_LEN_VAR);
            hdr_adr_reg <= (adr_mode != 2'h0);
          end
          if (rx_stop) state_reg <= rph_pkg::RPH_IDLE;
        end
        rph_pkg::RPH_RX_DATA: begin
          if (rx_byte_stb_reg) begin
            pn9_reg <= pn_out[16:8];
            crc_reg <= crc_byte(crc_reg, rx_plain);
            if (hdr_len_reg) begin
              hdr_len_reg <= 1'b0;
              cur_len_reg <= rx_plain;
              rx_push_reg <= 1'b1;
              rx_push_data_reg <= rx_plain;
              if (rx_plain > packet_length_limit_reg) begin
                state_reg <= rph_pkg::RPH_RX_HUNT;
                drop_reg <= 1'b1;
              end
            end else begin
              hdr_adr_reg <= 1'b0;
              byte_cnt_reg <= byte_cnt_next;
              rx_push_reg <= 1'b1;
              rx_push_data_reg <= rx_plain;
              if (hdr_adr_reg && !adr_ok) begin
                rx_push_reg <= 1'b0;
                drop_reg <= 1'b1;
                state_reg <= rph_pkg::RPH_RX_HUNT;
              end else if (at_end) begin
                sync_idx_reg <= 3'h0;
                state_reg <= crc_en ? rph_pkg::RPH_RX_CRC :
                             append_en ? rph_pkg::RPH_RX_ST1 :
                             rx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
                crc_bad_reg <= 1'b0;
              end
            end
          end
          if (rx_stop) state_reg <= rph_pkg::RPH_IDLE;
        end
        rph_pkg::RPH_RX_CRC: if (rx_byte_stb_reg) begin
          pn9_reg <= pn_out[16:8];
          rx_crc_reg <= {rx_crc_reg[7:0], rx_plain};
          sync_idx_reg <= sync_idx_reg + `RPH_ONE3;
          if (sync_idx_reg[0]) begin
            crc_bad_reg <= ({rx_crc_reg[7:0], rx_plain} != crc_reg);
            if (({rx_crc_reg[7:0], rx_plain} != crc_reg) && flush_en) begin
              flush_reg <= 1'b1;
              state_reg <= rx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
            end else state_reg <= append_en ? rph_pkg::RPH_RX_ST1 :
                                  rx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
          end
        end
        rph_pkg::RPH_RX_ST1: begin
          rx_push_reg <= 1'b1;
          rx_push_data_reg <= signal_strength_value_i;
          state_reg <= rph_pkg::RPH_RX_ST2;
        end
        rph_pkg::RPH_RX_ST2: begin
          rx_push_reg <= 1'b1;
          rx_push_data_reg <= {!(crc_en && crc_bad_reg), link_quality_value_i};
          state_reg <= rx_next_is_rx ? rph_pkg::RPH_RX_HUNT : rph_pkg::RPH_IDLE;
        end
        default: state_reg <= rph_pkg::RPH_IDLE;
      endcase
    end
  end

  // Register file; length and automation control may change mid packet.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      packet_automation_control_reg <= `RPH_AUTO_RST;
      packet_filter_control_reg <= `RPH_FILT_RST;
      packet_length_limit_reg <= `RPH_LEN_RST;
      sync_high_byte_reg <= `RPH_SYNCHI_RST;
      sync_low_byte_reg <= `RPH_SYNCLO_RST;
      modem_config_b_reg <= `RPH_MDMB_RST;
      modem_config_c_reg <= `RPH_MDMC_RST;
      node_address_reg <= 8'h00;
      pq_threshold_reg <= `RPH_PQT_RST;
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_next : 8'h00;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `RPH_A_AUTOCTL: packet_automation_control_reg <= reg_wdata_i;
          `RPH_A_FILTCTL: packet_filter_control_reg <= reg_wdata_i;
          `RPH_A_LENLIM:  packet_length_limit_reg <= reg_wdata_i;
          `RPH_A_SYNCHI:  sync_high_byte_reg <= reg_wdata_i;
          `RPH_A_SYNCLO:  sync_low_byte_reg <= reg_wdata_i;
          `RPH_A_MDMB:    modem_config_b_reg <= reg_wdata_i;
          `RPH_A_MDMC:    modem_config_c_reg <= reg_wdata_i;
          `RPH_A_ADDR:    node_address_reg <= reg_wdata_i;
          `RPH_A_PQT:     pq_threshold_reg <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    case (reg_addr_i)
      `RPH_A_AUTOCTL: rdata_next = packet_automation_control_reg;
      `RPH_A_FILTCTL: rdata_next = packet_filter_control_reg;
      `RPH_A_LENLIM:  rdata_next = packet_length_limit_reg;
      `RPH_A_SYNCHI:  rdata_next = sync_high_byte_reg;
      `RPH_A_SYNCLO:  rdata_next = sync_low_byte_reg;
      `RPH_A_MDMB:    rdata_next = modem_config_b_reg;
      `RPH_A_MDMC:    rdata_next = modem_config_c_reg;
      `RPH_A_ADDR:    rdata_next = node_address_reg;
      `RPH_A_STATUS:  rdata_next = {crc_bad_reg, 3'h0, state_reg};
      `RPH_A_PQT:     rdata_next = pq_threshold_reg;
      default:        rdata_next = 8'h00;
    endcase
  end

  assign tx_fifo_pop_o    = (state_reg == rph_pkg::RPH_TX_DATA) && tx_go && tx_fifo_valid_i;
  assign tx_byte_o        = tx_byte_reg;
  assign tx_byte_valid_o  = tx_valid_reg;
  assign rx_fifo_push_o   = rx_push_reg;
  assign rx_fifo_data_o   = rx_push_data_reg;
  assign rx_fifo_flush_o  = flush_reg;
  assign rx_packet_drop_o = drop_reg;
  assign fec_enable_o     = modem_config_b_reg[`RPH_BIT_FEC];
  assign tx_active_o      = (state_reg >= rph_pkg::RPH_TX_PRE) && (state_reg <= rph_pkg::RPH_TX_UFLOW);
  assign rx_active_o      = (state_reg >= rph_pkg::RPH_RX_HUNT);
endmodule

// file: rph_packet_handler_properties.sv
`timescale 1ns/1ps
`include "rph_consts.svh"
module rph_packet_handler_properties (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       tx_fifo_valid_i,
  input wire logic       tx_fifo_pop_o,
  input wire logic       tx_byte_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic       tx_byte_ready_i,
  input wire logic       rx_fifo_push_o,
  input wire logic       rx_fifo_flush_o,
  input wire logic       rx_packet_drop_o,
  input wire logic       fec_enable_o,
  input wire logic       tx_active_o,
  input wire logic       rx_active_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire cmd_w = reg_wr_i && reg_addr_i == `RPH_A_CMD;
  a_pop_with_data: assert property (tx_fifo_pop_o |-> tx_fifo_valid_i && tx_active_o)
    else $error("pop without data");
  a_dir_exclusive: assert property (!(tx_active_o && rx_active_o))
    else $error("tx and rx both active");
  a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > `RPH_A_PQT |=> !reg_rdata_o)
    else $error("unmapped read not zero");
  a_byte_holds: assert property (tx_byte_valid_o && !tx_byte_ready_i |=>
    tx_byte_valid_o && $stable(tx_byte_o))
    else $error("byte changed while stalled");
  a_fec_follows: assert property (reg_wr_i && reg_addr_i == `RPH_A_MDMB |=>
    fec_enable_o == $past(reg_wdata_i[`RPH_BIT_FEC]))
    else $error("fec enable not updated");
  a_tx_starts: assert property (cmd_w && reg_wdata_i == 8'h01 && !tx_active_o |->
    ##[1:2] tx_active_o)
    else $error("transmit did not start");
  a_flush_cmd: assert property (cmd_w && reg_wdata_i[`RPH_CMD_SFRX] |->
    ##[1:2] rx_fifo_flush_o)
    else $error("receive flush missing");
  c_pop: cover property (tx_fifo_pop_o);
  c_push: cover property (rx_fifo_push_o);
  c_drop: cover property (rx_packet_drop_o);
endmodule
bind rph_packet_handler rph_packet_handler_properties i_rph_packet_handler_properties (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .tx_fifo_valid_i(tx_fifo_valid_i), .tx_fifo_pop_o(tx_fifo_pop_o),
  .tx_byte_valid_o(tx_byte_valid_o), .tx_byte_o(tx_byte_o), .tx_byte_ready_i(tx_byte_ready_i),
  .rx_fifo_push_o(rx_fifo_push_o), .rx_fifo_flush_o(rx_fifo_flush_o),
  .rx_packet_drop_o(rx_packet_drop_o), .fec_enable_o(fec_enable_o),
  .tx_active_o(tx_active_o), .rx_active_o(rx_active_o));

// file: rph_host_fifo.sv
`timescale 1ns/1ps
module rph_host_fifo (
  input  wire logic       sys_clk_i,
  input  wire logic       pop_i,
  output logic            valid_o,
  output logic      [7:0] data_o
);
  logic [7:0] q[$];
  logic [7:0] last_reg = 8'h00;
  initial valid_o = 1'b0;
  initial data_o = 8'h00;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  task automatic flush();
    q.delete();
  endtask
  // An empty FIFO shows no stale head byte.
  always @(posedge sys_clk_i) begin
    if (pop_i && q.size() != 0) last_reg = q.pop_front();
    valid_o <= q.size() != 0;
    data_o <= q.size() != 0 ? q[0] : ~last_reg;
  end
endmodule

// file: tb_rph_packet_handler.sv
`timescale 1ns/1ps
`include "rph_consts.svh"
module tb_rph_packet_handler;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rdy = 1'b1;
  logic        bv = 1'b0;
  logic        bd = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rdata, txb, rxd, fdata;
  logic        fv, pop, tv, push, flush, drop, fec, txa, rxa;
  logic [7:0]  tq[$], rq[$];
  logic [15:0] crc;
  int          fail_count = 0;
  int          checks = 0;
  int          drops = 0;
  logic [3:0]  ra[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hF};
  logic [7:0]  rv[10] = '{`RPH_AUTO_RST, `RPH_FILT_RST, `RPH_LEN_RST, `RPH_SYNCHI_RST,
    `RPH_SYNCLO_RST, `RPH_MDMB_RST, `RPH_MDMC_RST, 8'h00, `RPH_PQT_RST, 8'h00};
  rph_packet_handler i_rph_packet_handler (
    .sys_clk_i(sys_clk), .rstn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_fifo_valid_i(fv), .tx_fifo_data_i(fdata),
    .tx_fifo_pop_o(pop), .tx_byte_valid_o(tv), .tx_byte_o(txb), .tx_byte_ready_i(rdy),
    .rx_bit_valid_i(bv), .rx_bit_i(bd), .signal_strength_value_i(8'h9C),
    .link_quality_value_i(7'h2B), .preamble_quality_indicator_i(8'h00), .rx_fifo_push_o(push),
    .rx_fifo_data_o(rxd), .rx_fifo_flush_o(flush), .rx_packet_drop_o(drop),
    .fec_enable_o(fec), .tx_active_o(txa), .rx_active_o(rxa));
  rph_host_fifo i_rph_host_fifo (.sys_clk_i(sys_clk), .pop_i(pop), .valid_o(fv), .data_o(fdata));
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (tv && rdy) tq.push_back(txb);
    if (push) rq.push_back(rxd);
    if (drop) drops++;
    rdy <= slow ? ~rdy : 1'b1;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge sys_clk);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c = `RPH_CRC_SEED;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ (`RPH_CRC_POLY & {16{c[15] ^ d[i]}});
    return c;
  endfunction
  // Early packets are loaded before the start command; late ones after a long wait.
  task automatic tx_pkt(input logic [7:0] ctl, len, input bit early, input logic [7:0] d[$]);
    tq.delete();
    wr_reg(`RPH_A_AUTOCTL, ctl);
    wr_reg(`RPH_A_LENLIM, len);
    if (early) foreach (d[i]) i_rph_host_fifo.push(d[i]);
    wr_reg(`RPH_A_CMD, 8'h01);
    repeat (30) @(posedge sys_clk);
    if (!early) foreach (d[i]) i_rph_host_fifo.push(d[i]);
    if (!early && ctl[1]) wr_reg(`RPH_A_AUTOCTL, 8'h00);
    for (int k = 0; k < 3000 && (txa !== 1'b0 || tv !== 1'b0); k++) @(posedge sys_clk);
  endtask
  task automatic chk_tx(input logic [7:0] e[$]);
    int n;
    n = tq.size() - e.size();
    chk(16'(n >= 2), 16'h0001);
    foreach (tq[i]) chk(tq[i], i < n ? 8'hAA : e[i - n]);
  endtask
  task automatic rx_pkt(input logic [7:0] last);
    logic [7:0] s[5] = '{8'hAA, 8'hAA, `RPH_SYNCHI_RST, `RPH_SYNCLO_RST, last};
    foreach (s[j]) for (int i = 7; i >= 0; i--) begin
      bd <= s[j][i];
      bv <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bv <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (40) @(posedge sys_clk);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    wr_reg(`RPH_A_MDMB, 8'h30);
    slow <= 1'b1;
    tx_pkt(8'h00, 8'h03, 1'b1, '{8'h11, 8'h22, 8'h33});
    slow <= 1'b0;
    chk(tq.size(), 9);
    chk_tx('{8'hD3, 8'h91, 8'h11, 8'h22, 8'h33});
    rd_chk(`RPH_A_STATUS, 8'h00);
    wr_reg(`RPH_A_MDMC, 8'h03);
    repeat (2) begin
      tx_pkt(8'h40, 8'h01, 1'b0, '{8'h00});
      chk_tx('{8'hD3, 8'h91, 8'hD3, 8'h91, 8'hFF});
    end
    wr_reg(`RPH_A_MDMC, 8'h02);
    wr_reg(`RPH_A_SYNCHI, `RPH_PREAMBLE);
    crc = crc16(16'h1234);
    tx_pkt(8'h04, 8'h02, 1'b1, '{8'h12, 8'h34});
    chk_tx('{8'hAA, 8'h91, 8'h12, 8'h34, crc[15:8], crc[7:0]});
    wr_reg(`RPH_A_SYNCHI, `RPH_SYNCHI_RST);
    tx_pkt(8'h02, 8'h02, 1'b0, '{8'h12, 8'h34});
    chk_tx('{8'hD3, 8'h91, 8'h12, 8'h34});
    rd_chk(`RPH_A_STATUS, 8'h00);
    tx_pkt(8'h00, 8'h03, 1'b1, '{8'hAB});
    rd_chk(`RPH_A_STATUS, {4'h0, rph_pkg::RPH_TX_UFLOW});
    i_rph_host_fifo.push(8'hCD);
    repeat (20) @(posedge sys_clk);
    chk(tq.size(), 7);
    wr_reg(`RPH_A_CMD, 8'h08);
    i_rph_host_fifo.flush();
    rd_chk(`RPH_A_STATUS, 8'h00);
    wr_reg(`RPH_A_AUTOCTL, 8'h01);
    wr_reg(`RPH_A_LENLIM, 8'h03);
    wr_reg(`RPH_A_CMD, 8'h02);
    rx_pkt(8'h04);
    chk(drops, 1);
    wr_reg(`RPH_A_CMD, 8'h14);
    wr_reg(`RPH_A_AUTOCTL, 8'h00);
    wr_reg(`RPH_A_LENLIM, 8'h01);
    wr_reg(`RPH_A_FILTCTL, 8'h04);
    rq.delete();
    wr_reg(`RPH_A_CMD, 8'h02);
    rx_pkt(8'h5A);
    chk(rq.size(), 3);
    chk(rq[0], 8'h5A);
    chk(rq[1], 8'h9C);
    chk(rq[2], 8'hAB);
    finish_test();
  end
  initial begin
    #2400000;
    fail_count++;
    finish_test();
  end
endmodule
